// ### logic/pdsc_panel.sv
// Front panel display selection and interface lamp logic, APB slave
`timescale 1ns/1ps
`default_nettype none
module pdsc_panel import pdsc_pkg::*; (
	input wire logic pclk, // Clock, 200 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	output logic [5:0] sel_lamp, // One-hot display selection lamps
	output logic [2:0] unit_lamp, // Lamp code, pdsc_unit_t
	output logic remote_lamp, // Remote lamp
	output logic listen_lamp, // Listen lamp
	output logic talk_lamp, // Talk lamp
	output logic srq_lamp, // Service request lamp
	output logic [31:0] first_channel_readout, // First channel value
	output logic [31:0] second_channel_readout // Second channel value
);
	////////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [31:0] ctrl; // Control register
	logic signed [15:0] in_phase; // In-phase demodulator
	logic signed [15:0] quad; // Quadrature demodulator
	logic [15:0] in_phase_deg; // Input phase, centi-degree units
	logic [15:0] phase_ofs; // Phase offset, milli-degrees
	logic [15:0] offset_pct; // Applied offset percent
	logic [15:0] aux_mv; // Aux module output, millivolts
	logic [31:0] osc_hz; // Oscillator frequency
	pdsc_sel_t sel; // Displayed quantity
	logic local_remote; // Remote from local key
	logic cmd_busy; // Command executing
	logic [31:0] readout; // Digital readout value
	pdsc_unit_t next_unit; // Units for readout
	logic [31:0] next_readout; // Readout before register
	logic [15:0] magnitude; // Root of sum of squares
	logic sq_busy; // Root engine busy
	logic [31:0] sum_sq; // Squared sum
	logic [31:0] log_db; // Decibels below full scale
	logic [31:0] phase_diff; // Input minus offset
	logic pll_ok; // Phase lock permitted
	logic [31:0] evt; // Event strobes this write
	logic acc_w; // Write access phase
	pdsc_mode_t mode; // Output mode
	assign acc_w = psel && penable && pwrite && pready;
	assign evt = (acc_w && paddr == PDSC_EVT_OFS) ? pwdata : 32'h0000_0000;
	assign mode = pdsc_mode_t'(ctrl[PDSC_CTRL_MODE_LSB +: 2]);
	assign pll_ok = ctrl[PDSC_CTRL_OSC_BIT] && ctrl[PDSC_CTRL_INTREF_BIT]; // see [RULE20]
	// Decode of a mapped offset, used by the error logic only
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= PDSC_READ_OFS);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Arithmetic
	// Widen before squaring so the products keep all 32 bits
	assign sum_sq = 32'(in_phase) * 32'(in_phase) + 32'(quad) * 32'(quad); // see [RULE6]
	pdsc_sqrt #(.W(32)) u_sqrt (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(1'b1),
		.rad(sum_sq),
		.busy(sq_busy),
		.root(magnitude)
	);
	// Base-ten log by leading bit: 20*log10(2) is about 6.02 dB per octave,
	// coarse but monotonic; full scale is 2^15 counts
	always_comb begin
		int msb;
		msb = 0;
		for (int i = 0; i < 16; i++) begin
			if (magnitude[i]) begin
				msb = i;
			end
		end
		log_db = 32'((15 - msb) * 602 / 100); // see [RULE7]
	end
	assign phase_diff = 32'({in_phase_deg, 1'b0} * 5) - 32'(phase_ofs); // see [RULE8]
	////////////////////////////////////////////////////////////////////////////////
	// Readout mux
	always_comb begin
		next_readout = 32'h0000_0000;
		next_unit = PDSC_UNIT_V;
		case (sel)
			PDSC_SEL_CH1: begin // see [RULE5]
				case (mode)
					PDSC_MODE_XY: next_readout = 32'(in_phase); // see [RULE18]
					PDSC_MODE_RTH: next_readout = 32'(magnitude);
					PDSC_MODE_LOGR: begin
						next_readout = log_db;
						next_unit = PDSC_UNIT_DB;
					end
					default: next_readout = pll_ok ? 32'(magnitude) : 32'(in_phase); // see [RULE21]
				endcase
				if (ctrl[PDSC_CTRL_NORM_BIT] && mode != PDSC_MODE_LOGR) begin
					next_unit = PDSC_UNIT_PCT; // see [RULE4]
				end
			end
			PDSC_SEL_CH2: begin
				case (mode)
					PDSC_MODE_XY: next_readout = 32'(quad); // see [RULE18]
					PDSC_MODE_RTH,
					PDSC_MODE_LOGR: begin
						next_readout = phase_diff; // see [RULE19]
						next_unit = PDSC_UNIT_DEG;
					end
					default: next_readout = pll_ok ? 32'(quad) : 32'h0000_0000; // see [RULE21]
				endcase
				if (ctrl[PDSC_CTRL_NORM_BIT] && next_unit == PDSC_UNIT_V) begin
					next_unit = PDSC_UNIT_PCT; // see [RULE4]
				end
			end
			PDSC_SEL_PHASE: begin
				// Drop digits below 0.1 degree, never round up
				next_readout = 32'(phase_ofs / 16'(PDSC_PHASE_DIGIT)); // see [RULE9]
				next_unit = PDSC_UNIT_DEG;
			end
			PDSC_SEL_OFFSET: begin
				// One register for manual and auto offset alike
				next_readout = 32'(offset_pct); // see [RULE10]
				next_unit = PDSC_UNIT_PCT;
			end
			PDSC_SEL_FREQ: begin
				// Independent of reference source selection
				next_readout = (osc_hz >= 32'd1000) ? osc_hz / 32'd1000 : osc_hz; // see [RULE11]
				next_unit = (osc_hz >= 32'd1000) ? PDSC_UNIT_KHZ : PDSC_UNIT_HZ;
			end
			PDSC_SEL_AUX: begin
				next_readout = 32'(32'(aux_mv) * 100 / PDSC_AUX_FS_MV); // see [RULE12]
				next_unit = PDSC_UNIT_PCT;
			end
			default: next_readout = 32'h0000_0000;
		endcase
		// Volt scale is always V; the nanovolt lamp has no code at all, see [RULE3]
	end
	////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait state, error on unmapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			if (psel && !penable && !pwrite) begin
				case (paddr)
					PDSC_CTRL_OFS: prdata <= ctrl;
					PDSC_STAT_OFS: prdata <= {20'h00000, cmd_busy, sq_busy, srq_lamp,
						talk_lamp, listen_lamp, remote_lamp, 3'(sel), 3'(next_unit)};
					PDSC_IQ_OFS: prdata <= {quad, in_phase};
					PDSC_PHASE_OFS: prdata <= {phase_ofs, in_phase_deg};
					PDSC_MISC_OFS: prdata <= {aux_mv, offset_pct};
					PDSC_FREQ_OFS: prdata <= osc_hz;
					PDSC_READ_OFS: prdata <= readout;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= PDSC_CTRL_RST;
			in_phase <= '0;
			quad <= '0;
			in_phase_deg <= '0;
			phase_ofs <= '0;
			offset_pct <= '0;
			aux_mv <= '0;
			osc_hz <= '0;
		end else if (ce && acc_w) begin
			case (paddr)
				PDSC_CTRL_OFS: ctrl <= {26'h0, pwdata[5:0]};
				PDSC_IQ_OFS: {quad, in_phase} <= pwdata;
				PDSC_PHASE_OFS: {phase_ofs, in_phase_deg} <= pwdata;
				PDSC_MISC_OFS: {aux_mv, offset_pct} <= pwdata;
				PDSC_FREQ_OFS: osc_hz <= pwdata;
				default: ctrl <= ctrl;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Display key; ignored while host has control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel <= PDSC_SEL_CH1;
		end else if (ce && evt[PDSC_EVT_DISP_BIT] && !local_remote) begin // see [RULE13]
			if (sel == PDSC_SEL_AUX) begin
				sel <= PDSC_SEL_CH1; // see [RULE2]
			end else begin
				sel <= pdsc_sel_t'(3'(sel) + 3'h1); // see [RULE1]
			end
		end
	end
	// Local key toggles remote control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_remote <= 1'b0;
		end else if (ce && evt[PDSC_EVT_LOCAL_BIT]) begin
			local_remote <= !local_remote; // see [RULE13]
		end
	end
	// Command execution span; first character wins over done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_busy <= 1'b0;
			listen_lamp <= 1'b0;
			talk_lamp <= 1'b0;
			srq_lamp <= 1'b0;
		end else if (ce) begin
			if (evt[PDSC_EVT_FIRST_BIT]) begin
				cmd_busy <= 1'b1; // see [RULE14]
			end else if (evt[PDSC_EVT_DONE_BIT]) begin
				cmd_busy <= 1'b0;
			end
			if (evt[PDSC_EVT_FIRST_BIT]) begin
				listen_lamp <= 1'b1; // see [RULE15]
			end else if (evt[PDSC_EVT_TERM_BIT]) begin
				listen_lamp <= 1'b0;
			end
			if (evt[PDSC_EVT_TXRDY_BIT]) begin
				talk_lamp <= 1'b1; // see [RULE16]
			end else if (evt[PDSC_EVT_TXDONE_BIT]) begin
				talk_lamp <= 1'b0;
			end
			if (evt[PDSC_EVT_SRQ_BIT]) begin
				srq_lamp <= 1'b1; // see [RULE17]
			end else if (evt[PDSC_EVT_POLL_BIT]) begin
				srq_lamp <= 1'b0;
			end
		end
	end
	// Registered lamps and readouts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_lamp <= 1'b0;
			sel_lamp <= 6'h01;
			unit_lamp <= 3'h1;
			readout <= 32'h0000_0000;
			first_channel_readout <= 32'h0000_0000;
			second_channel_readout <= 32'h0000_0000;
		end else if (ce) begin
			remote_lamp <= local_remote || cmd_busy; // see [RULE14]
			sel_lamp <= 6'h01 << 3'(sel); // see [RULE1]
			unit_lamp <= 3'(next_unit); // see [RULE3]
			readout <= next_readout;
			if (sel == PDSC_SEL_CH1) begin
				first_channel_readout <= next_readout; // see [RULE5]
			end
			if (sel == PDSC_SEL_CH2) begin
				second_channel_readout <= next_readout;
			end
		end
	end
endmodule // pdsc_panel
`default_nettype wire

// ### logic/pdsc_sqrt.sv
// Sequential integer square root used for the magnitude
`timescale 1ns/1ps
`default_nettype none
module pdsc_sqrt import pdsc_pkg::*; #(
	parameter int W = 32 // Radicand width
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic start, // Begin a root
	input wire logic [W-1:0] rad, // Radicand
	output logic busy, // Root in progress
	output logic [W/2-1:0] root // Last result
);
	logic [W-1:0] rem; // Radicand latched at start, held while the bits are tried
	logic [W/2-1:0] acc; // Partial root
	logic [5:0] step; // Bit index counter
	logic [W/2-1:0] trial; // Candidate with current bit set
	assign trial = acc | (W/2)'(1) << step;
	// Bit by bit: keep each bit whose square fits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem <= '0;
			acc <= '0;
			step <= '0;
			busy <= 1'b0;
			root <= '0;
		end else if (ce) begin
			if (start && !busy) begin
				rem <= rad;
				acc <= '0;
				step <= 6'(W/2-1);
				busy <= 1'b1;
			end else if (busy) begin
				if ({{(W/2){1'b0}}, trial} * {{(W/2){1'b0}}, trial} <= {{W{1'b0}}, rem}) begin
					acc <= trial;
				end
				if (step == 6'h00) begin
					busy <= 1'b0;
					root <= ({{(W/2){1'b0}}, trial} * {{(W/2){1'b0}}, trial}
						<= {{W{1'b0}}, rem}) ? trial : acc;
				end else begin
					step <= step - 6'h01;
				end
			end
		end
	end
endmodule // pdsc_sqrt
`default_nettype wire

// ### shared/pdsc_pkg.sv
// Package of constants, register map and types for the panel display status block
// Notes on behaviour
// [RULE1] Display key advances readout, lights its indicator
// [RULE2] After last quantity, wrap to first
// [RULE3] Output shows one unit lamp, never nanovolts
// [RULE4] Normalized operation: percent, all unit lamps off
// [RULE5] First channel shows quantity chosen by mode
// [RULE6] Magnitude is root of summed squares
// [RULE7] Log magnitude is decibels below full scale
// [RULE8] Phase is input phase minus phase offset
// [RULE9] Phase readout truncates beyond four digits
// [RULE10] Offset shown in percent, manual or automatic alike
// [RULE11] Oscillator frequency shown even on external reference
// [RULE12] Auxiliary shown as percent of ten volts
// [RULE13] Local key toggles remote and local control
// [RULE14] Remote lamp lit from first character to completion
// [RULE15] Listen lamp lit until terminator received
// [RULE16] Talk lamp lit while response output pending
// [RULE17] Service lamp lit until host serial poll
// [RULE18] X/Y mode: in-phase then quadrature
// [RULE19] Magnitude modes: second channel carries phase
// [RULE20] Phase lock only with oscillator, internal reference
// [RULE21] Phase lock: magnitude and lock error shown
package pdsc_pkg;
	// APB register byte offsets
	localparam logic [7:0] PDSC_CTRL_OFS = 8'h00; // Control: mode, normalize, oscillator, reference, lock
	localparam logic [7:0] PDSC_EVT_OFS = 8'h04; // Event strobes (write only)
	localparam logic [7:0] PDSC_STAT_OFS = 8'h08; // Lamps and selection
	localparam logic [7:0] PDSC_IQ_OFS = 8'h0C; // In-phase [15:0], quadrature [31:16]
	localparam logic [7:0] PDSC_PHASE_OFS = 8'h10; // Input phase, phase offset
	localparam logic [7:0] PDSC_MISC_OFS = 8'h14; // Offset [15:0], aux [31:16]
	localparam logic [7:0] PDSC_FREQ_OFS = 8'h18; // Oscillator frequency in Hz
	localparam logic [7:0] PDSC_READ_OFS = 8'h1C; // Readout value only
	// Control bit positions
	localparam int PDSC_CTRL_MODE_LSB = 0; // Two bit output mode
	localparam int PDSC_CTRL_NORM_BIT = 2; // Normalized operation
	localparam int PDSC_CTRL_OSC_BIT = 3; // Oscillator option fitted
	localparam int PDSC_CTRL_INTREF_BIT = 4; // Internal reference selected
	localparam int PDSC_CTRL_LOCKED_BIT = 5; // Lock achieved
	// Event bit positions
	localparam int PDSC_EVT_DISP_BIT = 0; // Display key pressed
	localparam int PDSC_EVT_LOCAL_BIT = 1; // Local key pressed
	localparam int PDSC_EVT_FIRST_BIT = 2; // First command character
	localparam int PDSC_EVT_TERM_BIT = 3; // Terminator sensed
	localparam int PDSC_EVT_DONE_BIT = 4; // Command executed
	localparam int PDSC_EVT_TXRDY_BIT = 5; // Response output ready
	localparam int PDSC_EVT_TXDONE_BIT = 6; // Response sent
	localparam int PDSC_EVT_SRQ_BIT = 7; // Service request asserted
	localparam int PDSC_EVT_POLL_BIT = 8; // Serial poll completed
	// Reset value and fixed constants
	localparam logic [31:0] PDSC_CTRL_RST = 32'h0000_0000; // Control after reset
	localparam int PDSC_AUX_FS_MV = 10000; // Aux full scale, millivolts
	localparam int PDSC_PHASE_DIGIT = 100; // Milli-degrees per shown digit
	localparam int PDSC_SQRT_STEPS = 17; // Square root cycles per result, load plus 16 steps
	// Displayable quantities in key order
	typedef enum logic [2:0] {
		PDSC_SEL_CH1,
		PDSC_SEL_CH2,
		PDSC_SEL_PHASE,
		PDSC_SEL_OFFSET,
		PDSC_SEL_FREQ,
		PDSC_SEL_AUX
	} pdsc_sel_t;
	// Output mode selector codes
	typedef enum logic [1:0] {
		PDSC_MODE_XY,
		PDSC_MODE_RTH,
		PDSC_MODE_LOGR,
		PDSC_MODE_PLL
	} pdsc_mode_t;
	// Unit lamp codes
	typedef enum logic [2:0] {
		PDSC_UNIT_PCT,
		PDSC_UNIT_V,
		PDSC_UNIT_MV,
		PDSC_UNIT_UV,
		PDSC_UNIT_DEG,
		PDSC_UNIT_DB,
		PDSC_UNIT_HZ,
		PDSC_UNIT_KHZ
	} pdsc_unit_t;
endpackage

// ### testbench/pdsc_host.sv
// Host computer model: APB master standing in for the remote controller
`timescale 1ns/1ps
`default_nettype none
module pdsc_host (
	input wire logic pclk, // Clock
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [31:0] prdata, // APB read data
	output logic psel, // APB select
	output logic penable, // APB enable
	output logic pwrite, // APB direction
	output logic [7:0] paddr, // APB address
	output logic [31:0] pwdata // APB write data
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// One transfer; request held until ready is sampled, then address and data scrambled
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic tmo);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		tmo = 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				tmo = 1'b0;
				break;
			end
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // pdsc_host
`default_nettype wire

// ### testbench/pdsc_panel_asserts.sv
// Concurrent checks on the ports of the panel display and lamp block
`timescale 1ns/1ps
`default_nettype none
module pdsc_panel_asserts import pdsc_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic ce, // Clock enable
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [5:0] sel_lamp, // Selection lamps
	input wire logic [2:0] unit_lamp, // Unit code
	input wire logic remote_lamp, // Remote lamp
	input wire logic listen_lamp, // Listen lamp
	input wire logic talk_lamp, // Talk lamp
	input wire logic srq_lamp // Service lamp
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	logic evw; // Event write lands this edge
	logic acc; // Any write lands this edge
	logic pollq; // Poll landed one edge ago
	logic [2:0] ctrl; // Mode and normalize as last written
	assign acc = psel && penable && pready && pwrite && ce;
	assign evw = acc && paddr == PDSC_EVT_OFS;
	// Shadow of control, so unit checks know the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 3'h0;
		end else if (acc && paddr == PDSC_CTRL_OFS) begin
			ctrl <= pwdata[2:0];
		end
	end
	// Poll clears one edge late; the hold check must not trip in between
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pollq <= 1'b0;
		end else begin
			pollq <= evw && pwdata[PDSC_EVT_POLL_BIT];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_key;
		evw && pwdata[PDSC_EVT_DISP_BIT] && !pwdata[PDSC_EVT_LOCAL_BIT] && !remote_lamp;
	endsequence
	sequence s_steady;
		sel_lamp[0] && $past(sel_lamp[0], 3) && ctrl == $past(ctrl, 3);
	endsequence
	a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
	a_err_unmapped: assert property (s_setup ##0 (paddr > PDSC_READ_OFS) |=> pslverr)
		else $error("unmapped access not refused");
	a_sel_onehot: assert property ($onehot(sel_lamp)) else $error("selection not one-hot");
	a_sel_step: assert property (s_key |-> ##2 sel_lamp == {$past(sel_lamp[4:0], 2), $past(sel_lamp[5], 2)})
		else $error("display key did not advance");
	a_listen_set: assert property (evw && pwdata[PDSC_EVT_FIRST_BIT] |-> ##2 listen_lamp && remote_lamp)
		else $error("first character left lamps dark");
	a_listen_clear: assert property (evw && pwdata[PDSC_EVT_TERM_BIT] && !pwdata[PDSC_EVT_FIRST_BIT] |-> ##2 !listen_lamp)
		else $error("listen lamp kept after terminator");
	a_talk_set: assert property (evw && pwdata[PDSC_EVT_TXRDY_BIT] |-> ##2 talk_lamp) else $error("talk lamp dark");
	a_talk_clear: assert property (evw && pwdata[PDSC_EVT_TXDONE_BIT] && !pwdata[PDSC_EVT_TXRDY_BIT] |-> ##2 !talk_lamp)
		else $error("talk lamp kept after sending");
	a_srq_hold: assert property (srq_lamp && !(evw && pwdata[PDSC_EVT_POLL_BIT]) && !pollq |=> srq_lamp)
		else $error("service lamp dropped before poll");
	a_srq_set: assert property (evw && pwdata[PDSC_EVT_SRQ_BIT] |-> ##2 srq_lamp) else $error("service lamp dark");
	a_unit_volts: assert property (s_steady ##0 (!ctrl[2] && ctrl[1:0] != 2'h2) |->
		unit_lamp inside {PDSC_UNIT_V, PDSC_UNIT_MV, PDSC_UNIT_UV}) else $error("bad voltage unit");
	a_norm_pct: assert property (s_steady ##0 (ctrl[2] && ctrl[1:0] < 2'h2) |-> unit_lamp == PDSC_UNIT_PCT)
		else $error("unit lamp lit while normalized");
endmodule // pdsc_panel_asserts
bind pdsc_panel pdsc_panel_asserts pdsc_panel_asserts_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .sel_lamp(sel_lamp), .unit_lamp(unit_lamp),
	.remote_lamp(remote_lamp), .listen_lamp(listen_lamp), .talk_lamp(talk_lamp), .srq_lamp(srq_lamp));
`default_nettype wire

// ### testbench/test_panel_display_status_control.sv
// Self-checking bench for the panel display and lamp block
`timescale 1ns/1ps
`default_nettype none
module test_panel_display_status_control import pdsc_pkg::*;;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, tmo;
	logic remote_lamp, listen_lamp, talk_lamp, srq_lamp;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, first_channel_readout, second_channel_readout;
	logic [5:0] sel_lamp;
	logic [2:0] unit_lamp;
	logic [15:0] lfsr, iv, qv;
	int mismatches, n_tests, idx, ii, qq;
	// Command life cycle: event bit and lamps {remote, listen, talk, srq} after it
	int evs[7] = '{PDSC_EVT_FIRST_BIT, PDSC_EVT_TERM_BIT, PDSC_EVT_SRQ_BIT, PDSC_EVT_TXRDY_BIT,
		PDSC_EVT_TXDONE_BIT, PDSC_EVT_DONE_BIT, PDSC_EVT_POLL_BIT};
	logic [3:0] lamps[7] = '{4'hC, 4'h8, 4'h9, 4'hB, 4'h9, 4'h1, 4'h0};
	// Control per mode case; odd entries expect the magnitude
	logic [31:0] ctrl_tab[4] = '{32'h00, 32'h01, 32'h03, 32'h3B};
	pdsc_panel pdsc_panel_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sel_lamp(sel_lamp), .unit_lamp(unit_lamp),
		.remote_lamp(remote_lamp), .listen_lamp(listen_lamp), .talk_lamp(talk_lamp),
		.srq_lamp(srq_lamp), .first_channel_readout(first_channel_readout),
		.second_channel_readout(second_channel_readout));
	pdsc_host pdsc_host_i (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	////////////////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Bus cycle; a hung slave ends the run
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		pdsc_host_i.xfer(wr, a, d, rd, err, tmo);
		if (tmo) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// One event strobe, then one edge for the lamps to follow
	task automatic ev(input int b);
		bus(1'b1, PDSC_EVT_OFS, 32'h1 << b);
		@(posedge pclk);
		#1;
	endtask
	task automatic press();
		ev(PDSC_EVT_DISP_BIT);
		idx = (idx + 1) % 6;
		check(sel_lamp, 32'h1 << idx);
	endtask
	// Wait long enough for the root iterations, then sample
	task automatic settle();
		repeat (40) @(posedge pclk);
		#1;
	endtask
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] isqrt(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h0;
		while ((r + 1) * (r + 1) <= v) r++;
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		lfsr = 16'h0026;
		mismatches = 0;
		n_tests = 0;
		idx = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		check(sel_lamp, 32'h1);
		check(unit_lamp, PDSC_UNIT_V);
		for (int i = 0; i < 7; i++) press(); // Seven presses cross the wrap
		$display("display key test done");
		for (int i = 0; i < 7; i++) begin
			ev(evs[i]);
			check({remote_lamp, listen_lamp, talk_lamp, srq_lamp}, lamps[i]);
		end
		bus(1'b0, PDSC_STAT_OFS, 32'h0);
		check(rd[9:3], {4'h0, 3'(idx)});
		$display("lamp test done");
		ev(PDSC_EVT_LOCAL_BIT);
		check(remote_lamp, 1'b1);
		ev(PDSC_EVT_DISP_BIT); // Ignored while remote
		check(sel_lamp, 32'h1 << idx);
		ev(PDSC_EVT_LOCAL_BIT);
		check(remote_lamp, 1'b0);
		bus(1'b0, 8'h40, 32'h0);
		check({err, rd}, {1'b1, 32'h0});
		$display("local and refusal test done");
		for (int k = 0; k < 4; k++) begin
			lfsr = next_rand(lfsr);
			iv = {lfsr[15], lfsr[15:1]};
			lfsr = next_rand(lfsr);
			qv = {lfsr[15], lfsr[15:1]};
			ii = $signed(iv);
			qq = $signed(qv);
			bus(1'b1, PDSC_IQ_OFS, {qv, iv});
			while (idx != 0) press();
			for (int m = 0; m < 4; m++) begin
				bus(1'b1, PDSC_CTRL_OFS, ctrl_tab[m]);
				settle();
				check(first_channel_readout, m[0] ? isqrt(32'(ii * ii + qq * qq)) : {{16{iv[15]}}, iv});
			end
			bus(1'b1, PDSC_CTRL_OFS, 32'h0);
			settle();
			check(unit_lamp inside {PDSC_UNIT_V, PDSC_UNIT_MV, PDSC_UNIT_UV}, 1'b1);
			bus(1'b1, PDSC_CTRL_OFS, 32'h1 << PDSC_CTRL_NORM_BIT);
			settle();
			check(unit_lamp, PDSC_UNIT_PCT);
			bus(1'b1, PDSC_CTRL_OFS, 32'h0);
			press();
			settle();
			check(second_channel_readout, {{16{qv[15]}}, qv});
		end
		$display("channel test done");
		// Other readouts: 45.00 deg input, 1.250 deg offset, 37 %, aux 2.5 V, 40 kHz
		bus(1'b1, PDSC_PHASE_OFS, {16'd1250, 16'd4500});
		bus(1'b1, PDSC_MISC_OFS, {16'd2500, 16'd37});
		bus(1'b1, PDSC_FREQ_OFS, 32'd40000);
		bus(1'b1, PDSC_CTRL_OFS, 32'h1);
		settle();
		bus(1'b0, PDSC_READ_OFS, 32'h0);
		check(rd, 32'd45000 - 32'd1250);
		check(second_channel_readout, 32'd45000 - 32'd1250);
		press();
		bus(1'b0, PDSC_READ_OFS, 32'h0);
		check(rd, 32'd12);
		press();
		bus(1'b0, PDSC_READ_OFS, 32'h0);
		check({unit_lamp, rd}, {PDSC_UNIT_PCT, 32'd37});
		press();
		bus(1'b0, PDSC_READ_OFS, 32'h0);
		check({unit_lamp, rd}, {PDSC_UNIT_KHZ, 32'd40});
		press();
		bus(1'b0, PDSC_READ_OFS, 32'h0);
		check({unit_lamp, rd}, {PDSC_UNIT_PCT, 32'd2500 * 32'd100 / 32'd10000});
		press();
		$display("readout test done");
		wrap_up();
	end
endmodule // test_panel_display_status_control
`default_nettype wire
